// file: hw/tpr_pkg.sv
// tpr_pkg: register map, field positions, reset values and timing for the timer block.
// assumes a 32-bit classic wishbone slave with one aligned word per register.
package tpr_pkg;
	// register byte offsets
	localparam logic [3:0] TPR_OFF_OPTION = 4'h0;
	localparam logic [3:0] TPR_OFF_COUNT = 4'h4;
	localparam logic [3:0] TPR_OFF_INTCTL = 4'h8;
	localparam logic [3:0] TPR_OFF_WDTCTL = 4'hC;
	// option register fields
	localparam int TPR_BIT_PULLUP_DIS = 7;
	localparam int TPR_BIT_EXT_EDGE = 6;
	localparam int TPR_BIT_CLK_SEL = 5;
	localparam int TPR_BIT_EDGE_SEL = 4;
	localparam int TPR_BIT_PSA = 3;
	localparam int TPR_RATE_MSB = 2;
	localparam logic [7:0] TPR_OPTION_RESET = 8'hFF;
	// interrupt control fields
	localparam int TPR_BIT_IRQ_EN = 5;
	localparam int TPR_BIT_OVF_FLAG = 2;
	localparam logic [7:0] TPR_INTCTL_RESET = 8'h00;
	// watchdog control register: bit 0 write-one issues a watchdog clear
	localparam int TPR_BIT_WDT_CLR = 0;
	localparam logic [7:0] TPR_COUNT_RESET = 8'h00;
	localparam logic [7:0] TPR_PRESC_RESET = 8'h00;
	// inhibit after a count write, in instruction cycles
	localparam logic [1:0] TPR_WRITE_INHIBIT = 2'h2;
	// instruction cycle phases, one phase per clock
	localparam logic [1:0] TPR_PHASE_Q2 = 2'h1;
	localparam logic [1:0] TPR_PHASE_Q4 = 2'h3;
endpackage

// file: hw/tpr_timer.sv
// tpr_timer: 8-bit timer/counter with a prescaler shared with the watchdog.
// assumes clock_i is the phase clock (4 per instruction cycle), wishbone master on clock_i.
`timescale 1ns/1ps
module tpr_timer
	import tpr_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// core side
	input wire logic sleep_i,
	input wire logic watchdog_clear_instr_i,
	output logic watchdog_tick_o,
	output logic watchdog_clear_o,
	output logic timer_irq_o,
	output logic ext_irq_edge_select_o,
	output logic port_b_pullup_disable_o,
	// external pulse source
	input wire logic timer_count_pin_i
);

	logic [7:0] timer_option_config;
	logic [7:0] timer_count;
	logic [7:0] interrupt_control;
	logic [7:0] presc;
	logic [1:0] phase;
	logic [1:0] inhibit;
	logic [1:0] pin_sync;
	logic pin_last;
	logic src_last;
	logic presc_out_q;
	logic ack;
	logic wr_cyc;
	logic hit_opt;
	logic hit_cnt;
	logic hit_int;
	logic hit_wdt;
	logic count_wr;
	logic wdt_clr;
	logic instr_tick;
	logic src_edge;
	logic src_pulse;
	logic presc_tap;
	logic presc_rise;
	logic inc;
	logic wrap;
	logic prescaler_assign_bit;
	logic [2:0] rate;
	logic [7:0] next_count;
	// pending increments, kept until the next q2/q4 sampling point
	logic src_pulse_held;
	logic presc_rise_held;
	logic sample_pt;

	// decode a byte address against one register offset
	function automatic logic reg_hit(input logic [3:0] adr, input logic [3:0] off);
		return adr == off;
	endfunction

	assign prescaler_assign_bit = timer_option_config[TPR_BIT_PSA];
	assign rate = timer_option_config[TPR_RATE_MSB:0];
	assign wr_cyc = wb_cyc_i && wb_stb_i && wb_we_i && !ack && wb_sel_i[0];
	assign hit_opt = reg_hit(wb_adr_i, TPR_OFF_OPTION);
	assign hit_cnt = reg_hit(wb_adr_i, TPR_OFF_COUNT);
	assign hit_int = reg_hit(wb_adr_i, TPR_OFF_INTCTL);
	assign hit_wdt = reg_hit(wb_adr_i, TPR_OFF_WDTCTL);
	assign count_wr = wr_cyc && hit_cnt;
	assign wdt_clr = watchdog_clear_instr_i
		|| (wr_cyc && hit_wdt && wb_dat_i[TPR_BIT_WDT_CLR]);

	// single-wait-state slave; unmapped offsets answer with err
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			ack <= 1'b0;
		end else begin
			ack <= wb_cyc_i && wb_stb_i && !ack;
		end
	end
	assign wb_ack_o = ack && (hit_opt || hit_cnt || hit_int || hit_wdt);
	assign wb_err_o = ack && !(hit_opt || hit_cnt || hit_int || hit_wdt);

	// prescaler never on the read path
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !ack) begin
			wb_dat_o <= 32'h0000_0000;
			if (hit_opt)
				wb_dat_o[7:0] <= timer_option_config;
			else if (hit_cnt)
				wb_dat_o[7:0] <= timer_count;
			else if (hit_int)
				wb_dat_o[7:0] <= interrupt_control;
		end
	end

	// option register holds assignment and rates
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			timer_option_config <= TPR_OPTION_RESET;
		end else if (wr_cyc && hit_opt) begin
			timer_option_config <= wb_dat_i[7:0];
		end
	end

	assign ext_irq_edge_select_o = timer_option_config[TPR_BIT_EXT_EDGE];
	assign port_b_pullup_disable_o = timer_option_config[TPR_BIT_PULLUP_DIS];

	// phase counter, one instruction cycle per four clocks
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end
	assign instr_tick = phase == TPR_PHASE_Q4;

	// pin passes two flops before edge detection
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			pin_sync <= 2'h0;
			pin_last <= 1'b0;
		end else begin
			pin_sync <= {pin_sync[0], timer_count_pin_i};
			pin_last <= pin_sync[1];
		end
	end

	assign src_edge = timer_option_config[TPR_BIT_EDGE_SEL]
		? (pin_last && !pin_sync[1]) : (!pin_last && pin_sync[1]);

	// timer mode ticks once per instruction cycle
	assign src_pulse = timer_option_config[TPR_BIT_CLK_SEL] ? src_edge : instr_tick;

	// one shared divider, cleared by its owner
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			presc <= TPR_PRESC_RESET;
		end else if ((!prescaler_assign_bit && count_wr) || (prescaler_assign_bit && wdt_clr)) begin
			presc <= TPR_PRESC_RESET;
		end else if (prescaler_assign_bit ? instr_tick : src_pulse) begin
			presc <= presc + 8'h01;
		end
	end

	// tap: timer uses bit rate, watchdog one lower; rate 0 on wdt bypasses
	always_comb begin
		presc_tap = 1'b0;
		if (!prescaler_assign_bit)
			presc_tap = presc[rate];
		else if (rate != 3'h0)
			presc_tap = presc[rate - 3'h1];
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			presc_out_q <= 1'b0;
			src_last <= 1'b0;
		end else begin
			presc_out_q <= presc_tap;
			src_last <= presc_out_q;
		end
	end
	// divided output falls once per full divide period
	assign presc_rise = src_last && !presc_out_q;

	assign watchdog_tick_o = prescaler_assign_bit && (rate == 3'h0 ? instr_tick : presc_rise);
	assign watchdog_clear_o = wdt_clr;

	// undivided only when prescaler is with watchdog; sampled on q2/q4
	assign inc = !sleep_i && inhibit == 2'h0
		&& sample_pt
		&& (prescaler_assign_bit ? src_pulse_held : presc_rise_held);

	// edges are held until the next q2/q4 sampling point
	// a pulse landing on a sampling point is kept for the next one, never lost:
	// the timer-mode tick always falls on q4
	assign sample_pt = phase == TPR_PHASE_Q2 || phase == TPR_PHASE_Q4;
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			src_pulse_held <= 1'b0;
			presc_rise_held <= 1'b0;
		end else begin
			src_pulse_held <= (src_pulse_held && !sample_pt) || src_pulse;
			presc_rise_held <= (presc_rise_held && !sample_pt) || presc_rise;
		end
	end

	// inhibit for two instruction cycles after a count write
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			inhibit <= 2'h0;
		end else if (count_wr) begin
			inhibit <= TPR_WRITE_INHIBIT;
		end else if (instr_tick && inhibit != 2'h0) begin
			inhibit <= inhibit - 2'h1;
		end
	end

	// natural wrap, flag pulse in the same cycle
	assign next_count = timer_count + 8'h01;
	assign wrap = inc && timer_count == 8'hFF;

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			timer_count <= TPR_COUNT_RESET;
		end else if (count_wr) begin
			timer_count <= wb_dat_i[7:0];
		end else if (inc) begin
			timer_count <= next_count;
		end
	end

	// flag set wins over a software clear
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			interrupt_control <= TPR_INTCTL_RESET;
		end else begin
			if (wr_cyc && hit_int)
				interrupt_control <= wb_dat_i[7:0];
			if (wrap)
				interrupt_control[TPR_BIT_OVF_FLAG] <= 1'b1;
		end
	end

	assign timer_irq_o = interrupt_control[TPR_BIT_OVF_FLAG]
		&& interrupt_control[TPR_BIT_IRQ_EN];

	property p_flag_on_wrap;
		@(posedge clock_i) disable iff (!rst_b_i)
		wrap |=> interrupt_control[TPR_BIT_OVF_FLAG];
	endproperty
	a_flag_on_wrap: assert property (p_flag_on_wrap) else $error("overflow flag not set");

	property p_flag_sticky;
		@(posedge clock_i) disable iff (!rst_b_i)
		interrupt_control[TPR_BIT_OVF_FLAG] && !(wr_cyc && hit_int)
			|=> interrupt_control[TPR_BIT_OVF_FLAG];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by hardware");

	property p_irq_gate;
		@(posedge clock_i) disable iff (!rst_b_i)
		timer_irq_o == (interrupt_control[TPR_BIT_OVF_FLAG] && interrupt_control[TPR_BIT_IRQ_EN]);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without flag and enable");

	property p_sleep_frozen;
		@(posedge clock_i) disable iff (!rst_b_i)
		sleep_i && !count_wr |=> $stable(timer_count);
	endproperty
	a_sleep_frozen: assert property (p_sleep_frozen) else $error("count moved in sleep");

	sequence s_count_write;
		count_wr;
	endsequence
	property p_inhibit;
		@(posedge clock_i) disable iff (!rst_b_i)
		s_count_write |=> !inc [*4];
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("increment right after write");

	property p_presc_clr_timer;
		@(posedge clock_i) disable iff (!rst_b_i)
		!prescaler_assign_bit && count_wr |=> presc == TPR_PRESC_RESET;
	endproperty
	a_presc_clr_timer: assert property (p_presc_clr_timer) else $error("prescaler not cleared");

	property p_presc_clr_wdt;
		@(posedge clock_i) disable iff (!rst_b_i)
		prescaler_assign_bit && wdt_clr |=> presc == TPR_PRESC_RESET;
	endproperty
	a_presc_clr_wdt: assert property (p_presc_clr_wdt) else $error("wdt clear missed prescaler");

	property p_exclusive;
		@(posedge clock_i) disable iff (!rst_b_i)
		!prescaler_assign_bit |-> !watchdog_tick_o;
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("watchdog ticked while timer owns");

	property p_sample_phase;
		@(posedge clock_i) disable iff (!rst_b_i)
		inc |-> (phase == TPR_PHASE_Q2 || phase == TPR_PHASE_Q4);
	endproperty
	a_sample_phase: assert property (p_sample_phase) else $error("increment off q2/q4");

	property p_wrap_zero;
		@(posedge clock_i) disable iff (!rst_b_i)
		wrap && !count_wr |=> timer_count == TPR_COUNT_RESET;
	endproperty
	a_wrap_zero: assert property (p_wrap_zero) else $error("count did not wrap to zero");

	property p_count_load;
		@(posedge clock_i) disable iff (!rst_b_i)
		s_count_write |=> timer_count == $past(wb_dat_i[7:0]);
	endproperty
	a_count_load: assert property (p_count_load) else $error("count write not loaded");

	property p_inhibit_load;
		@(posedge clock_i) disable iff (!rst_b_i)
		s_count_write |=> inhibit == TPR_WRITE_INHIBIT;
	endproperty
	a_inhibit_load: assert property (p_inhibit_load) else $error("inhibit not armed");

	property p_option_load;
		@(posedge clock_i) disable iff (!rst_b_i)
		wr_cyc && hit_opt |=> timer_option_config == $past(wb_dat_i[7:0]);
	endproperty
	a_option_load: assert property (p_option_load) else $error("option write lost");

	property p_wdt_bypass;
		@(posedge clock_i) disable iff (!rst_b_i)
		prescaler_assign_bit && rate == 3'h0 |-> watchdog_tick_o == instr_tick;
	endproperty
	a_wdt_bypass: assert property (p_wdt_bypass) else $error("watchdog 1:1 tick wrong");

	property p_presc_hold_wdt;
		@(posedge clock_i) disable iff (!rst_b_i)
		prescaler_assign_bit && !instr_tick && !wdt_clr |=> $stable(presc);
	endproperty
	a_presc_hold_wdt: assert property (p_presc_hold_wdt) else $error("divider moved idle");

	property p_presc_hold_tmr;
		@(posedge clock_i) disable iff (!rst_b_i)
		!prescaler_assign_bit && !count_wr && !src_pulse |=> $stable(presc);
	endproperty
	a_presc_hold_tmr: assert property (p_presc_hold_tmr) else $error("divider moved idle");

	property p_irq_on_wrap;
		@(posedge clock_i) disable iff (!rst_b_i)
		wrap && interrupt_control[TPR_BIT_IRQ_EN] && !(wr_cyc && hit_int) |=> timer_irq_o;
	endproperty
	a_irq_on_wrap: assert property (p_irq_on_wrap) else $error("no irq after wrap");

	property p_wdt_clear_out;
		@(posedge clock_i) disable iff (!rst_b_i)
		watchdog_clear_instr_i |-> watchdog_clear_o;
	endproperty
	a_wdt_clear_out: assert property (p_wdt_clear_out) else $error("clear not passed on");

endmodule

// file: bench/tpr_pulse_src.sv
// tpr_pulse_src: behavioural pulse source for the timer count pin.
// assumes edges are slow enough for the two-flop synchroniser and the phase sampling.
`timescale 1ns/1ps
module tpr_pulse_src (
	// clock
	input wire logic clock_i,
	// count pin
	output logic pin_o
);
	// the pin holds its level between bursts, like a real idle source
	initial pin_o = 1'b0;

	// four clocks per level so every edge survives one whole instruction cycle
	task edges(input int n);
		repeat (n) begin
			repeat (4) @(posedge clock_i);
			pin_o <= ~pin_o;
		end
	endtask
endmodule

// file: bench/tpr_timer_tb.sv
// tpr_timer_tb: register, overflow, edge, prescaler and sleep tests for the timer.
// assumes one-cycle wishbone answers and the pulse source model on the count pin.
`timescale 1ns/1ps
module tpr_timer_tb;
	import tpr_pkg::*;
	logic clock_i = 0, rst_b_i = 0, cyc = 0, stb = 0, we = 0, sleep = 0, wclr = 0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack, err, wtick, wclr_o, irq, edge_o, pull_o, pin;
	logic [32:0] expq[$];
	logic [32:0] e;
	logic [7:0] v;
	int mismatches = 0, cmp_count = 0, cycles = 0, seed = 32'hcba5, i, n;

	always #50 clock_i = ~clock_i;

	tpr_timer i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .wb_err_o(err), .sleep_i(sleep), .watchdog_clear_instr_i(wclr),
		.watchdog_tick_o(wtick), .watchdog_clear_o(wclr_o), .timer_irq_o(irq),
		.ext_irq_edge_select_o(edge_o), .port_b_pullup_disable_o(pull_o),
		.timer_count_pin_i(pin));
	tpr_pulse_src i_src (.clock_i(clock_i), .pin_o(pin));

	task check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// request held until the edge that samples the answer
	task xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do @(posedge clock_i); while (ack !== 1'b1 && err !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task wr(input logic [3:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask

	task rd(input logic [3:0] a, input logic [7:0] d);
		expq.push_back({9'h0, 24'h0, d});
		xfer(1'b0, a, 8'h00);
	endtask

	task pulse(input int n);
		repeat (12) @(posedge clock_i);
		i_src.edges(n);
		repeat (12) @(posedge clock_i);
	endtask

	// oldest note is matched against each read answer
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles > 40000) begin
			mismatches++;
			finish_test;
		end
		if (cyc && !we && (ack === 1'b1 || err === 1'b1)) begin
			e = expq.pop_front();
			check("read", {err, (err === 1'b1) ? 32'h0 : rdat}, e);
		end
	end

	initial begin
		repeat (16) @(posedge clock_i);
		rst_b_i <= 1'b1;
		rd(TPR_OFF_OPTION, TPR_OPTION_RESET);
		rd(TPR_OFF_INTCTL, TPR_INTCTL_RESET);
		rd(TPR_OFF_COUNT, TPR_COUNT_RESET);
		expq.push_back(33'h1_0000_0000);
		xfer(1'b0, 4'h2, 8'h00);
		check("pins", {31'h0, edge_o, pull_o}, 33'h3);
		$display("reset test done");
		wr(TPR_OFF_OPTION, 8'hE8);
		wr(TPR_OFF_COUNT, 8'hFF);
		pulse(1);
		rd(TPR_OFF_COUNT, 8'h00);
		rd(TPR_OFF_INTCTL, 8'h04);
		check("irq", {32'h0, irq}, 33'h0);
		wr(TPR_OFF_INTCTL, 8'h24);
		rd(TPR_OFF_INTCTL, 8'h24);
		check("irq", {32'h0, irq}, 33'h1);
		wr(TPR_OFF_INTCTL, 8'h20);
		rd(TPR_OFF_INTCTL, 8'h20);
		check("irq", {32'h0, irq}, 33'h0);
		$display("overflow test done");
		wr(TPR_OFF_OPTION, 8'hF8);
		wr(TPR_OFF_COUNT, 8'h00);
		pulse(1);
		rd(TPR_OFF_COUNT, 8'h01);
		pulse(1);
		rd(TPR_OFF_COUNT, 8'h01);
		$display("edge test done");
		wr(TPR_OFF_WDTCTL, 8'h01);
		for (i = 0; i < 8; i++) begin
			wr(TPR_OFF_OPTION, 8'hE0 | i[7:0]);
			wr(TPR_OFF_COUNT, 8'h00);
			// one rising edge short of two increments
			pulse(2 * ((2 ** (i + 2)) - 1));
			rd(TPR_OFF_COUNT, 8'h01);
		end
		$display("prescaler test done");
		wr(TPR_OFF_WDTCTL, 8'h01);
		wr(TPR_OFF_COUNT, 8'h00);
		wr(TPR_OFF_OPTION, 8'hE8);
		wr(TPR_OFF_WDTCTL, 8'h01);
		wr(TPR_OFF_OPTION, 8'hED);
		@(posedge clock_i);
		wclr <= 1'b1;
		@(negedge clock_i);
		check("wdt clear", {32'h0, wclr_o}, 33'h1);
		@(posedge clock_i);
		wclr <= 1'b0;
		wr(TPR_OFF_COUNT, 8'h00);
		pulse(6);
		rd(TPR_OFF_COUNT, 8'h03);
		wr(TPR_OFF_OPTION, 8'hC8);
		sleep <= 1'b1;
		wr(TPR_OFF_COUNT, 8'h10);
		n = 0;
		repeat (100) begin
			@(posedge clock_i);
			if (wtick === 1'b1) n++;
		end
		check("wdt tick", n, 33'd25);
		rd(TPR_OFF_COUNT, 8'h10);
		sleep <= 1'b0;
		$display("switch and sleep test done");
		repeat (4) begin
			v = 8'($random(seed));
			wr(TPR_OFF_OPTION, v);
			rd(TPR_OFF_OPTION, v);
			check("pins", {31'h0, edge_o, pull_o}, {31'h0, v[6], v[7]});
		end
		$display("register test done");
		finish_test;
	end
endmodule
